// >>> logic/pbd_pkg.sv
package pbd_pkg;
  // ****************************************
  // register offsets and reset values
  // ****************************************
  localparam logic [7:0] PBD_CFG_OFS = 8'h00;
  localparam logic [7:0] PBD_CTRL_OFS = 8'h04;
  localparam logic [7:0] PBD_STAT_OFS = 8'h08;
  localparam logic [7:0] PBD_CMD_OFS = 8'h0C;
  localparam logic [31:0] PBD_CFG_RST = 32'h0008_4003;
  // ****************************************
  // configuration and control field positions
  // ****************************************
  localparam int PBD_CFG_EN = 0;
  localparam int PBD_CFG_DEB = 1;
  localparam int PBD_CFG_LONG = 4;
  localparam int PBD_CFG_DBL_EN = 7;
  localparam int PBD_CFG_DBL = 8;
  localparam int PBD_CFG_MODE = 11;
  localparam int PBD_CFG_STEP = 14;
  localparam int PBD_CFG_BLK_EN = 17;
  localparam int PBD_CFG_BLK_INV = 18;
  localparam int PBD_CFG_BSET = 19;
  localparam int PBD_CFG_BCLR = 21;
  localparam int PBD_CFG_RACT = 23;
  localparam int PBD_CFG_RDLY = 25;
  localparam int PBD_CTRL_BLK = 0;
  localparam int PBD_CTRL_RESTORE = 1;
  // ****************************************
  // mode, response and dim step codes
  // ****************************************
  localparam logic [2:0] PBD_MODE_ONE = 3'h0;
  localparam logic [2:0] PBD_MODE_BRT_ON = 3'h1;
  localparam logic [2:0] PBD_MODE_BRT_TGL = 3'h2;
  localparam logic [2:0] PBD_MODE_DRK_OFF = 3'h3;
  localparam logic [2:0] PBD_MODE_DRK_TGL = 3'h4;
  localparam logic [1:0] PBD_BSET_IGN = 2'h0;
  localparam logic [1:0] PBD_BSET_NONE = 2'h1;
  localparam logic [1:0] PBD_BSET_ON = 2'h2;
  localparam logic [1:0] PBD_RESP_NONE = 2'h0;
  localparam logic [1:0] PBD_RESP_ON = 2'h1;
  localparam logic [2:0] PBD_STEP_STOP = 3'h0;
  // ****************************************
  // timing
  // ****************************************
  localparam int PBD_CLK_NS = 10;
  localparam int PBD_TICK_NS = 1000000;
  localparam int PBD_TICK_CYC_DEF = PBD_TICK_NS / PBD_CLK_NS;
  localparam int PBD_LONG_BASE_MS = 300;
  localparam int PBD_LONG_STEP_MS = 100;
  localparam int PBD_RST_STEP_MS = 5000;

  // debounce delay in ms ticks
  function automatic logic [13:0] pbd_deb_ms(input logic [2:0] sel);
    case (sel)
      3'h0: return 14'h001E;
      3'h1: return 14'h0032;
      3'h2: return 14'h0050;
      3'h3: return 14'h0064;
      3'h4: return 14'h00C8;
      3'h5: return 14'h03E8;
      3'h6: return 14'h1388;
      default: return 14'h2710;
    endcase
  endfunction : pbd_deb_ms

  // 300 ms to 1 s in 100 ms steps
  function automatic logic [13:0] pbd_step_ms(input logic [2:0] sel);
    return 14'(PBD_LONG_BASE_MS + PBD_LONG_STEP_MS * int'(sel));
  endfunction : pbd_step_ms

  // 0, 5, 10 or 15 s
  function automatic logic [13:0] pbd_rst_ms(input logic [1:0] sel);
    return 14'(PBD_RST_STEP_MS * int'(sel));
  endfunction : pbd_rst_ms
endpackage : pbd_pkg

// >>> logic/pbd_tick_cnt.sv
`timescale 1ns/100ps
module pbd_tick_cnt
  import pbd_pkg::*;
#(
  parameter int W = 14
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // control
  input wire logic tick,
  input wire logic clr,
  // elapsed ticks, saturating
  output logic [W-1:0] cnt
);
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= '0;
    end else if (clr) begin
      cnt <= '0;
    end else if (tick && cnt != {W{1'b1}}) begin
      cnt <= cnt + W'(1);
    end
  end
endmodule : pbd_tick_cnt

// >>> logic/pbd_channel.sv
`timescale 1ns/100ps
// Contract
// RULE1: accept a new contact level only after it stays stable for the debounce delay
// RULE2: press held at least the long threshold is long, shorter is short
// RULE3: double-click only if second press begins within the window, else single clicks
// RULE4: block object polarity selectable, default 1 blocks, inverted 0 blocks
// RULE5: long and short presses trigger two different dimming functions
// RULE6: single button: short toggles, long dims alternately, release stops
// RULE7: rocker variants bind the channel to one fixed dimming direction
// RULE8: brighter variants: short on or toggle, long brighter, release stop
// RULE9: darker variants: short off or toggle, long darker, release stop
// RULE10: 100 percent increment dims continuously until release
// RULE11: partial increment changes the value by that step per long press
// RULE12: on restoration send nothing, switch-on or switch-off as configured
// RULE13: delayed restoration response waits 5, 10 or 15 s first
// RULE14: ignore setting leaves the channel unaffected by block telegrams
// RULE15: on block set send nothing, on or off as configured
// RULE16: on block cancel send nothing, on or off as configured
// RULE17: while blocked, button presses produce no commands
module pbd_channel
  import pbd_pkg::*;
#(
  parameter int TICK_CYC = PBD_TICK_CYC_DEF
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // contact pin
  input wire logic contact_input_one,
  // commands to the dimming actuator
  output logic cmd_valid,
  output logic cmd_is_dim,
  output logic cmd_switch_on,
  output logic [3:0] cmd_dim_code,
  output logic dbl_click
);
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_PRESS = 5'h02,
    ST_LONG = 5'h04,
    ST_WAIT = 5'h08,
    ST_DBL = 5'h10
  } pbd_st_t;

  pbd_st_t st_ff, nxt_st;
  logic [31:0] cfg_ff, rd_data, prdata_ff;
  logic ctrl_blk_ff, pready_ff, pslverr_ff, rd_err, wr_en;
  logic [16:0] pre_ff;
  logic tick_ff;
  logic [2:0] sync_ff;
  logic deb_ff, deb_clr, deb_take, pclr;
  logic [13:0] deb_cnt, pcnt, rcnt, deb_lim, long_lim, win_lim, rdly_lim;
  logic ev_short, ev_long, ev_stop, ev_dbl;
  logic blk_req, blocked_ff, blk_rise, blk_fall;
  logic rst_pend_ff, rst_trig, rst_fire;
  logic toggle_state_ff, dir_ff, brt_mode, tgl_mode, long_dir, from_btn, btn_src_ff;
  logic nxt_valid, nxt_dim, nxt_on;
  logic [3:0] nxt_code;
  logic cmd_valid_ff, cmd_is_dim_ff, cmd_switch_on_ff, dbl_click_ff;
  logic [3:0] cmd_dim_code_ff;
  logic [2:0] mode, step;
  logic [1:0] bset, bclr, ract, rdly_sel;
  logic en, dbl_en, blk_en, blk_inv;

  // ****************************************
  // configuration fields
  // ****************************************
  assign en = cfg_ff[PBD_CFG_EN];
  assign dbl_en = cfg_ff[PBD_CFG_DBL_EN];
  assign blk_en = cfg_ff[PBD_CFG_BLK_EN];
  assign blk_inv = cfg_ff[PBD_CFG_BLK_INV];
  assign mode = cfg_ff[PBD_CFG_MODE +: 3];
  assign step = cfg_ff[PBD_CFG_STEP +: 3];
  assign bset = cfg_ff[PBD_CFG_BSET +: 2];
  assign bclr = cfg_ff[PBD_CFG_BCLR +: 2];
  assign ract = cfg_ff[PBD_CFG_RACT +: 2];
  assign rdly_sel = cfg_ff[PBD_CFG_RDLY +: 2];
  assign deb_lim = pbd_deb_ms(cfg_ff[PBD_CFG_DEB +: 3]);
  assign long_lim = pbd_step_ms(cfg_ff[PBD_CFG_LONG +: 3]);
  assign win_lim = pbd_step_ms(cfg_ff[PBD_CFG_DBL +: 3]);
  assign rdly_lim = pbd_rst_ms(rdly_sel);

  // ****************************************
  // apb slave
  // ****************************************
  assign wr_en = psel && penable && pwrite && pready_ff;
  assign rst_trig = wr_en && paddr == PBD_CTRL_OFS && pwdata[PBD_CTRL_RESTORE];

  always_comb begin
    rd_data = 32'h0;
    rd_err = 1'b0;
    case (paddr)
      PBD_CFG_OFS: rd_data = cfg_ff;
      PBD_CTRL_OFS: rd_data = {31'h0, ctrl_blk_ff};
      PBD_STAT_OFS: rd_data = {27'h0, rst_pend_ff, st_ff[2], toggle_state_ff, blocked_ff, deb_ff};
      PBD_CMD_OFS: rd_data = {26'h0, cmd_is_dim_ff, cmd_switch_on_ff, cmd_dim_code_ff};
      default: rd_err = 1'b1;
    endcase
  end

  // one wait state, answer registered
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff <= 32'h0;
    end else if (psel && penable && !pready_ff) begin
      pready_ff <= 1'b1;
      pslverr_ff <= rd_err;
      prdata_ff <= pwrite ? 32'h0 : rd_data;
    end else begin
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cfg_ff <= PBD_CFG_RST;
      ctrl_blk_ff <= 1'b0;
    end else if (wr_en && paddr == PBD_CFG_OFS) begin
      cfg_ff <= pwdata;
    end else if (wr_en && paddr == PBD_CTRL_OFS) begin
      ctrl_blk_ff <= pwdata[PBD_CTRL_BLK];
    end
  end

  // ****************************************
  // millisecond tick and contact debounce
  // ****************************************
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pre_ff <= 17'h0;
      tick_ff <= 1'b0;
    end else if (pre_ff == 17'(TICK_CYC - 1)) begin
      pre_ff <= 17'h0;
      tick_ff <= 1'b1;
    end else begin
      pre_ff <= pre_ff + 17'h1;
      tick_ff <= 1'b0;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sync_ff <= 3'h0;
    end else begin
      sync_ff <= {sync_ff[1:0], contact_input_one};
    end
  end

  // RULE1 stability timer
  assign deb_clr = sync_ff[1] != sync_ff[2] || sync_ff[2] == deb_ff;
  assign deb_take = !deb_clr && deb_cnt > deb_lim;

  pbd_tick_cnt #(.W(14)) u_deb_cnt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick_ff),
    .clr(deb_clr),
    .cnt(deb_cnt)
  );

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      deb_ff <= 1'b0;
    end else if (deb_take) begin
      deb_ff <= sync_ff[2];
    end
  end

  // ****************************************
  // press classification
  // ****************************************
  // RULE3 window runs from the start of the first press
  assign pclr = st_ff == ST_IDLE && nxt_st == ST_PRESS;

  pbd_tick_cnt #(.W(14)) u_press_cnt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick_ff),
    .clr(pclr),
    .cnt(pcnt)
  );

  // RULE2 RULE5 long versus short
  always_comb begin
    nxt_st = st_ff;
    ev_short = 1'b0;
    ev_long = 1'b0;
    ev_stop = 1'b0;
    ev_dbl = 1'b0;
    case (st_ff)
      ST_IDLE: begin
        if (en && deb_ff) nxt_st = ST_PRESS;
      end
      ST_PRESS: begin
        if (!deb_ff && dbl_en) begin
          nxt_st = ST_WAIT;
        end else if (!deb_ff) begin
          ev_short = 1'b1;
          nxt_st = ST_IDLE;
        end else if (pcnt > long_lim) begin
          ev_long = 1'b1;
          nxt_st = ST_LONG;
        end
      end
      ST_LONG: begin
        if (!deb_ff) begin
          ev_stop = 1'b1;
          nxt_st = ST_IDLE;
        end
      end
      // RULE3 second press within window
      // expiry wins over a press that lands on the window edge
      ST_WAIT: begin
        if (pcnt > win_lim) begin
          ev_short = 1'b1;
          nxt_st = ST_IDLE;
        end else if (deb_ff) begin
          ev_dbl = 1'b1;
          nxt_st = ST_DBL;
        end
      end
      ST_DBL: begin
        if (!deb_ff) nxt_st = ST_IDLE;
      end
      default: nxt_st = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      st_ff <= ST_IDLE;
    end else begin
      st_ff <= nxt_st;
    end
  end

  // ****************************************
  // block and restoration
  // ****************************************
  // RULE4 RULE14 polarity and ignore
  assign blk_req = blk_en && bset != PBD_BSET_IGN && ctrl_blk_ff != blk_inv;
  assign blk_rise = blk_req && !blocked_ff;
  assign blk_fall = !blk_req && blocked_ff;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      blocked_ff <= 1'b0;
    end else begin
      blocked_ff <= blk_req;
    end
  end

  pbd_tick_cnt #(.W(14)) u_rst_cnt (
    .clk_sys(clk_sys),
    .rst_n(rst_n),
    .tick(tick_ff),
    .clr(!rst_pend_ff || rst_trig),
    .cnt(rcnt)
  );

  // RULE13 delayed response
  assign rst_fire = rst_pend_ff && (rdly_sel == 2'h0 || rcnt > rdly_lim);

  // power-up counts as a restoration
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rst_pend_ff <= 1'b1;
    end else if (rst_trig) begin
      rst_pend_ff <= 1'b1;
    end else if (rst_fire) begin
      rst_pend_ff <= 1'b0;
    end
  end

  // ****************************************
  // command generation
  // ****************************************
  // RULE7 rocker direction fixed by mode
  assign brt_mode = mode == PBD_MODE_BRT_ON || mode == PBD_MODE_BRT_TGL;
  assign tgl_mode = mode == PBD_MODE_ONE || mode == PBD_MODE_BRT_TGL || mode == PBD_MODE_DRK_TGL;
  assign long_dir = mode == PBD_MODE_ONE ? dir_ff : brt_mode;

  always_comb begin
    nxt_valid = 1'b0;
    nxt_dim = 1'b0;
    nxt_on = 1'b0;
    nxt_code = 4'h0;
    from_btn = 1'b0;
    // RULE15 block set response
    if (blk_rise && bset != PBD_BSET_NONE) begin
      nxt_valid = 1'b1;
      nxt_on = bset == PBD_BSET_ON;
    // RULE16 block cancel response
    end else if (blk_fall && bclr != PBD_RESP_NONE) begin
      nxt_valid = 1'b1;
      nxt_on = bclr == PBD_RESP_ON;
    // RULE12 restoration response
    end else if (rst_fire && ract != PBD_RESP_NONE) begin
      nxt_valid = 1'b1;
      nxt_on = ract == PBD_RESP_ON;
    // RULE17 presses muted while blocked
    end else if (!blocked_ff && (ev_short || ev_long || ev_stop)) begin
      nxt_valid = 1'b1;
      from_btn = 1'b1;
      // RULE6 RULE8 RULE9 short press
      if (ev_short) begin
        nxt_on = tgl_mode ? !toggle_state_ff : brt_mode;
      end else begin
        nxt_dim = 1'b1;
        // RULE10 RULE11 step code, stop on release
        if (ev_long) nxt_code = {long_dir, step};
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      cmd_valid_ff <= 1'b0;
      cmd_is_dim_ff <= 1'b0;
      cmd_switch_on_ff <= 1'b0;
      cmd_dim_code_ff <= 4'h0;
      dbl_click_ff <= 1'b0;
      btn_src_ff <= 1'b0;
    end else begin
      cmd_valid_ff <= nxt_valid;
      dbl_click_ff <= ev_dbl && !blocked_ff;
      btn_src_ff <= from_btn;
      if (nxt_valid) begin
        cmd_is_dim_ff <= nxt_dim;
        cmd_switch_on_ff <= nxt_on;
        cmd_dim_code_ff <= nxt_code;
      end
    end
  end

  // RULE6 alternate direction in single-button mode
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      toggle_state_ff <= 1'b0;
      dir_ff <= 1'b1;
    end else begin
      if (nxt_valid && !nxt_dim) toggle_state_ff <= nxt_on;
      if (from_btn && ev_long && mode == PBD_MODE_ONE) dir_ff <= !dir_ff;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign cmd_valid = cmd_valid_ff;
  assign cmd_is_dim = cmd_is_dim_ff;
  assign cmd_switch_on = cmd_switch_on_ff;
  assign cmd_dim_code = cmd_dim_code_ff;
  assign dbl_click = dbl_click_ff;

  // ****************************************
  // assertions
  // ****************************************
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);

  a_debounce_hold: assert property ( // RULE1
    $changed(deb_ff) |-> $past(deb_cnt) > $past(deb_lim) && deb_ff == $past(sync_ff[2]))
    else $error("contact accepted before debounce delay");
  a_long_thresh: assert property ( // RULE2
    $rose(st_ff[2]) |-> $past(pcnt) > $past(long_lim) && $past(deb_ff))
    else $error("long press before threshold");
  a_dbl_window: assert property ( // RULE3
    dbl_click_ff |-> $past(st_ff[3]) && $past(pcnt) <= $past(win_lim))
    else $error("double-click outside window");
  a_block_polarity: assert property ( // RULE4
    (blk_en && bset != PBD_BSET_IGN && ctrl_blk_ff != blk_inv) [*2] |-> blocked_ff)
    else $error("block polarity not applied");
  a_one_btn_alt: assert property ( // RULE6
    from_btn && ev_long && mode == PBD_MODE_ONE |=> cmd_is_dim_ff && dir_ff != $past(dir_ff))
    else $error("single-button dim direction did not alternate");
  a_rocker_dir: assert property ( // RULE7
    from_btn && ev_long && mode != PBD_MODE_ONE |=> cmd_dim_code_ff[3] == $past(brt_mode))
    else $error("rocker dim direction wrong");
  a_step_code: assert property ( // RULE11
    cmd_valid_ff && cmd_is_dim_ff && cmd_dim_code_ff[2:0] != PBD_STEP_STOP
      |-> cmd_dim_code_ff[2:0] == $past(step))
    else $error("dim step differs from increment");
  a_release_stop: assert property ( // RULE10
    $fell(st_ff[2]) && !$past(blocked_ff) && !$past(blk_rise) && !$past(blk_fall)
      && !$past(rst_fire)
      |-> cmd_valid_ff && cmd_is_dim_ff && cmd_dim_code_ff == 4'h0)
    else $error("release did not stop dimming");
  a_restore_delay: assert property ( // RULE13
    $fell(rst_pend_ff) |-> $past(rdly_sel) == 2'h0 || $past(rcnt) > $past(rdly_lim))
    else $error("restoration response sent early");
  a_ignore_block: assert property ( // RULE14
    bset == PBD_BSET_IGN |=> !blocked_ff)
    else $error("ignored block took effect");
  a_block_set_on: assert property ( // RULE15
    blk_rise && bset == PBD_BSET_ON |=> cmd_valid_ff && !cmd_is_dim_ff && cmd_switch_on_ff)
    else $error("block set response missing");
  a_block_mute: assert property ( // RULE17
    $past(blocked_ff) && cmd_valid_ff |-> !btn_src_ff)
    else $error("button command while blocked");

  c_short_switch: cover property (cmd_valid_ff && !cmd_is_dim_ff && btn_src_ff);
  c_long_dim: cover property (cmd_valid_ff && cmd_is_dim_ff && cmd_dim_code_ff != 4'h0);
  c_double: cover property (dbl_click_ff);
  c_restore: cover property ($fell(rst_pend_ff) && rdly_sel != 2'h0);
endmodule : pbd_channel

// >>> sim/pbd_dim_model.sv
`timescale 1ns/100ps
// ****************************************
// dimming actuator at the far end of the bus
// ****************************************
module pbd_dim_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic rst_n,
  // telegrams from the channel
  input wire logic cmd_valid,
  input wire logic cmd_is_dim,
  input wire logic cmd_switch_on,
  input wire logic [3:0] cmd_dim_code,
  // what has arrived so far
  output logic [15:0] n_cmd_ff,
  output logic dim_ff,
  output logic sw_ff,
  output logic [3:0] code_ff
);
  // takes every telegram, no back-pressure
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      n_cmd_ff <= 16'h0000;
      dim_ff <= 1'b0;
      sw_ff <= 1'b0;
      code_ff <= 4'h0;
    end else if (cmd_valid === 1'b1) begin
      n_cmd_ff <= n_cmd_ff + 16'h0001;
      dim_ff <= cmd_is_dim;
      if (cmd_is_dim === 1'b1) begin
        code_ff <= cmd_dim_code;
      end else begin
        sw_ff <= cmd_switch_on;
      end
    end
  end
endmodule : pbd_dim_model

// >>> sim/tb.sv
`timescale 1ns/100ps
module tb;
  import pbd_pkg::*;
  // ****************************************
  // signals
  // ****************************************
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic contact = 1'b0;
  logic cmd_valid;
  logic cmd_is_dim;
  logic cmd_switch_on;
  logic [3:0] cmd_dim_code;
  logic dbl_click;
  logic [15:0] n_cmd;
  logic dim_l;
  logic sw_l;
  logic [3:0] code_l;
  logic [31:0] rd;
  logic err;
  logic [31:0] c;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc = 0;
  int dbl_n = 0;
  int n0;

  initial begin
    forever #5 clk_sys = ~clk_sys;
  end

  // 1 ms is 4 clock cycles here
  pbd_channel #(.TICK_CYC(4)) pbd_channel_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .contact_input_one(contact), .cmd_valid(cmd_valid), .cmd_is_dim(cmd_is_dim),
    .cmd_switch_on(cmd_switch_on), .cmd_dim_code(cmd_dim_code), .dbl_click(dbl_click)
  );
  pbd_dim_model pbd_dim_model_i (
    .clk_sys(clk_sys), .rst_n(rst_n), .cmd_valid(cmd_valid), .cmd_is_dim(cmd_is_dim),
    .cmd_switch_on(cmd_switch_on), .cmd_dim_code(cmd_dim_code), .n_cmd_ff(n_cmd),
    .dim_ff(dim_l), .sw_ff(sw_l), .code_ff(code_l)
  );

  always @(posedge clk_sys) begin
    if (dbl_click === 1'b1) dbl_n++;
    cyc++;
    if (cyc == 100000) begin
      error_cnt++;
      end_sim();
    end
  end

  // ****************************************
  // helpers
  // ****************************************
  task end_sim();
    $display("tests_run=%0d error_cnt=%0d", tests_run, error_cnt);
    if (error_cnt == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_sim

  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task apb(input logic wr_en, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr_en;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  // write, then expect dn switch telegrams carrying sw
  task wr_exp(input logic [7:0] a, input logic [31:0] d, input int dn, input logic sw);
    n0 = n_cmd;
    apb(1'b1, a, d);
    repeat (5) @(posedge clk_sys);
    chk(32'(n_cmd) - 32'(n0), 32'(dn));
    if (dn > 0) chk(32'({dim_l, sw_l}), 32'({1'b0, sw}));
  endtask : wr_exp

  // short press: exp[0] is the switch value; long press: exp is the dim code
  task push(input logic lng, input logic [3:0] exp);
    n0 = n_cmd;
    contact <= 1'b1;
    repeat (lng ? 2000 : 600) @(posedge clk_sys);
    if (lng) begin
      chk(32'(n_cmd), 32'(n0 + 1));
      chk(32'({dim_l, code_l}), 32'({1'b1, exp}));
    end
    contact <= 1'b0;
    repeat (600) @(posedge clk_sys);
    chk(32'(n_cmd), 32'(n0 + (lng ? 2 : 1)));
    if (lng) chk(32'(code_l), 32'h0000_0000);
    else chk(32'({dim_l, sw_l}), 32'({1'b0, exp[0]}));
  endtask : push

  // a press that must produce nothing
  task quiet(input int hold);
    n0 = n_cmd;
    contact <= 1'b1;
    repeat (hold) @(posedge clk_sys);
    contact <= 1'b0;
    repeat (600) @(posedge clk_sys);
    chk(32'(n_cmd), 32'(n0));
  endtask : quiet

  // ****************************************
  // scenarios
  // ****************************************
  task t_regs();
    apb(1'b0, PBD_CFG_OFS, 32'h0000_0000);
    chk(rd, PBD_CFG_RST);
    chk(32'(err), 32'h0000_0000);
    apb(1'b0, 8'h10, 32'h0000_0000);
    chk(32'(err), 32'h0000_0001);
    chk(rd, 32'h0000_0000);
    chk(32'(n_cmd), 32'h0000_0000);
  endtask : t_regs

  task t_single();
    quiet(100);
    push(1'b0, {3'h0, !sw_l});
    push(1'b0, {3'h0, !sw_l});
    push(1'b1, 4'h9);
    push(1'b1, 4'h1);
  endtask : t_single

  task t_rocker();
    for (int m = 1; m < 5; m++) begin
      c = PBD_CFG_RST;
      c[13:11] = 3'(m);
      c[16:14] = 3'h2;
      apb(1'b1, PBD_CFG_OFS, c);
      push(1'b0, {3'h0, (m == 1) ? 1'b1 : (m == 3) ? 1'b0 : !sw_l});
      push(1'b1, {m < 3, 3'h2});
    end
  endtask : t_rocker

  task t_block();
    c = PBD_CFG_RST;
    c[PBD_CFG_BLK_EN] = 1'b1;
    c[20:19] = 2'h2;
    c[22:21] = 2'h2;
    wr_exp(PBD_CFG_OFS, c, 0, 1'b0);
    wr_exp(PBD_CTRL_OFS, 32'h0000_0001, 1, 1'b1);
    quiet(600);
    wr_exp(PBD_CTRL_OFS, 32'h0000_0000, 1, 1'b0);
    c[PBD_CFG_BLK_INV] = 1'b1;
    c[20:19] = 2'h3;
    c[22:21] = 2'h1;
    wr_exp(PBD_CFG_OFS, c, 1, 1'b0);
    wr_exp(PBD_CTRL_OFS, 32'h0000_0001, 1, 1'b1);
    c[PBD_CFG_BLK_INV] = 1'b0;
    c[20:19] = 2'h0;
    wr_exp(PBD_CFG_OFS, c, 0, 1'b0);
    push(1'b0, {3'h0, !sw_l});
    wr_exp(PBD_CTRL_OFS, 32'h0000_0000, 0, 1'b0);
  endtask : t_block

  task t_dbl();
    c = PBD_CFG_RST;
    c[PBD_CFG_DBL_EN] = 1'b1;
    apb(1'b1, PBD_CFG_OFS, c);
    n0 = n_cmd;
    dbl_n = 0;
    contact <= 1'b1;
    repeat (300) @(posedge clk_sys);
    contact <= 1'b0;
    repeat (300) @(posedge clk_sys);
    contact <= 1'b1;
    repeat (300) @(posedge clk_sys);
    contact <= 1'b0;
    repeat (2400) @(posedge clk_sys);
    chk(32'(dbl_n), 32'h0000_0001);
    chk(32'(n_cmd), 32'(n0));
    // second press after the window: two single clicks
    n0 = n_cmd;
    repeat (2) begin
      contact <= 1'b1;
      repeat (300) @(posedge clk_sys);
      contact <= 1'b0;
      repeat (2400) @(posedge clk_sys);
    end
    chk(32'(n_cmd), 32'(n0 + 2));
    chk(32'(dbl_n), 32'h0000_0001);
  endtask : t_dbl

  task t_restore();
    c = PBD_CFG_RST;
    c[24:23] = 2'h1;
    wr_exp(PBD_CFG_OFS, c, 0, 1'b0);
    wr_exp(PBD_CTRL_OFS, 32'h0000_0002, 1, 1'b1);
    c[24:23] = 2'h2;
    c[26:25] = 2'h1;
    wr_exp(PBD_CFG_OFS, c, 0, 1'b0);
    wr_exp(PBD_CTRL_OFS, 32'h0000_0002, 0, 1'b0);
    // 5 s is 20000 cycles at this tick
    repeat (19000) @(posedge clk_sys);
    chk(32'(n_cmd), 32'(n0));
    repeat (2000) @(posedge clk_sys);
    chk(32'({n_cmd, dim_l, sw_l}), 32'({16'(n0 + 1), 2'b00}));
  endtask : t_restore

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    repeat (16) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    t_regs();
    t_single();
    t_rocker();
    t_block();
    t_dbl();
    t_restore();
    end_sim();
  end
endmodule : tb
